// file: verilog/fsb_pkg.sv
`default_nettype none
package fsb_pkg;
  localparam int FSB_ADDR_W = 5;
  localparam int FSB_PADDR_W = 8;
  // register offsets (byte addresses)
  localparam logic [7:0] FSB_OFF_CTRL = 8'h00;
  localparam logic [7:0] FSB_OFF_STATUS = 8'h04;
  localparam logic [7:0] FSB_OFF_STORE = 8'h80;
  // control word fields
  localparam int FSB_CTRL_START_BIT = 0;
  localparam int FSB_CTRL_ADDR_LSB = 8;
  // status word fields
  localparam int FSB_STAT_STATE_LSB = 0;
  localparam int FSB_STAT_PC_LSB = 8;
  localparam int FSB_STAT_OUT_LSB = 16;
  // control-store word fields
  localparam int FSB_STEP_NEXT_LSB = 0;
  localparam int FSB_STEP_BR_LSB = 8;
  localparam int FSB_STEP_CODE_LSB = 16;
  localparam int FSB_STEP_PCRC_BIT = 22;
  localparam int FSB_STEP_ALT_BIT = 23;
  // branch codes
  localparam logic [2:0] FSB_BC_000 = 3'h0;
  localparam logic [2:0] FSB_BC_001 = 3'h1;
  localparam logic [2:0] FSB_BC_010 = 3'h2;
  localparam logic [2:0] FSB_BC_011 = 3'h3;
  localparam logic [2:0] FSB_BC_100 = 3'h4;
  localparam logic [2:0] FSB_BC_101 = 3'h5;
  localparam logic [2:0] FSB_BC_110 = 3'h6;
  localparam logic [2:0] FSB_BC_111 = 3'h7;
  // reset values
  localparam logic [FSB_ADDR_W-1:0] FSB_RST_PC = 5'h00;
  localparam logic [FSB_ADDR_W-1:0] FSB_RST_START = 5'h00;

  typedef enum logic [1:0] {
    FSB_GO_NEXT = 2'b00,
    FSB_GO_BRANCH = 2'b01,
    FSB_GO_STOP = 2'b10
  } fsb_outcome_t;

  typedef enum logic [1:0] {
    FSB_ST_IDLE = 2'b00,
    FSB_ST_RUN = 2'b01,
    FSB_ST_STOP = 2'b10
  } fsb_state_t;

  typedef struct packed {
    logic alt_sel;
    logic process_crc;
    logic [2:0] code;
    logic [FSB_ADDR_W-1:0] branch_addr;
    logic [FSB_ADDR_W-1:0] next_addr;
  } fsb_step_t;

  typedef struct packed {
    logic crc_error;
    logic compare_ne;
    logic id_field_flag;
    logic sector_mark_detect;
    logic read_gate;
  } fsb_cond_t;
endpackage : fsb_pkg
`default_nettype wire

// file: verilog/fsb_branch_decode.sv
`timescale 1ns/100ps
`default_nettype none
module fsb_branch_decode
  import fsb_pkg::*;
(
  input wire fsb_step_t i_step,
  input wire fsb_cond_t i_cond,
  output var logic o_use_alt,
  output var fsb_outcome_t o_outcome
);
  logic use_alt;
  logic bad;

  always_comb
  begin
    // alternate set only without select bit and without crc in progress
    use_alt = !i_step.alt_sel && (!i_step.process_crc || !i_cond.read_gate);
    bad = i_cond.compare_ne || i_cond.crc_error;
    o_outcome = FSB_GO_NEXT;
    if (use_alt)
    begin
      unique case (i_step.code)
        FSB_BC_000: o_outcome = FSB_GO_NEXT;
        FSB_BC_001: o_outcome = i_cond.id_field_flag ? FSB_GO_STOP : FSB_GO_NEXT;
        FSB_BC_010: o_outcome = i_cond.sector_mark_detect ? FSB_GO_STOP : FSB_GO_NEXT;
        FSB_BC_011: o_outcome = i_cond.compare_ne ? FSB_GO_STOP : FSB_GO_NEXT;
        FSB_BC_100: o_outcome = FSB_GO_BRANCH;
        FSB_BC_101: o_outcome = i_cond.id_field_flag ? FSB_GO_BRANCH : FSB_GO_NEXT;
        // codes 110 and 111 carry no meaning here, so fall through
        FSB_BC_110, FSB_BC_111: o_outcome = FSB_GO_NEXT;
      endcase
    end
    else
    begin
      unique case (i_step.code)
        FSB_BC_000, FSB_BC_001: o_outcome = FSB_GO_NEXT;
        FSB_BC_010: o_outcome = i_cond.compare_ne ? FSB_GO_STOP : FSB_GO_NEXT;
        FSB_BC_011: o_outcome = bad ? FSB_GO_STOP : FSB_GO_NEXT;
        FSB_BC_100: o_outcome = bad ? FSB_GO_NEXT : FSB_GO_BRANCH;
        FSB_BC_101: o_outcome = i_cond.crc_error ? FSB_GO_BRANCH : FSB_GO_NEXT;
        FSB_BC_110: o_outcome = i_cond.compare_ne ? FSB_GO_BRANCH : FSB_GO_NEXT;
        FSB_BC_111: o_outcome = bad ? FSB_GO_BRANCH : FSB_GO_NEXT;
      endcase
    end
    o_use_alt = use_alt;
  end
endmodule : fsb_branch_decode
`default_nettype wire

// file: verilog/fsb_sequencer.sv
// What this block does
// - primary code 101 branches on crc error, else next address.
// - primary code 110 branches on compare unequal, else next address.
// - primary code 111 branches on unequal or crc error, else next.
// - alternate set when select bit clear and (process crc clear or read gate low).
// - alternate code 000 always continues at next address.
// - alternate code 001 stops on id field flag, else next.
// - alternate code 010 stops on sector mark detect, else next.
// - alternate code 011 stops on compare unequal, else next.
// - alternate code 100 always takes the branch address.
// - alternate code 101 branches on id field flag, else next.
// - primary code 100 branches on good crc and equal compare, else next.
// - primary code 011 stops on unequal or crc error, else next.
// - primary code 010 stops on compare unequal, else next.
`timescale 1ns/100ps
`default_nettype none
module fsb_sequencer
  import fsb_pkg::*;
#(
  parameter int STEPS = 31
)
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [FSB_PADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_crc_error,
  input wire logic i_compare_ne,
  input wire logic i_id_field_flag,
  input wire logic i_sector_mark_detect,
  input wire logic i_read_gate,
  output logic [FSB_ADDR_W-1:0] o_step_addr,
  output logic o_running,
  output logic o_stopped
);
  if (STEPS < 1 || STEPS > 2 ** FSB_ADDR_W)
  begin : g_bad_steps
    $error("STEPS must lie between 1 and 32");
  end

  // pin synchronisers
  logic [2:0] pin_meta_reg, pin_sync_reg;
  logic [2:0] pin_raw;
  assign pin_raw = {i_id_field_flag, i_sector_mark_detect, i_read_gate};
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // apb slave: pready comes one cycle after setup, so every access has one wait-free access cycle
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [FSB_ADDR_W-1:0] start_addr_reg, start_addr_next;
  logic setup, access, hit_ctrl, hit_status, hit_store;
  logic [FSB_PADDR_W-1:0] store_off;
  logic [FSB_ADDR_W-1:0] store_idx;
  logic wr_ctrl, wr_store, start_wr;

  fsb_state_t state_reg, state_next;
  logic [FSB_ADDR_W-1:0] pc_reg, pc_next;
  fsb_outcome_t last_out_reg, last_out_next;
  fsb_step_t store_reg [STEPS];
  fsb_step_t store_next [STEPS];
  fsb_step_t cur_step, wr_step;
  fsb_cond_t cond;
  fsb_outcome_t outcome;
  logic use_alt;

  function automatic logic [31:0] step_word(input fsb_step_t s);
    logic [31:0] w;
    w = 32'h0;
    w[FSB_STEP_NEXT_LSB +: FSB_ADDR_W] = s.next_addr;
    w[FSB_STEP_BR_LSB +: FSB_ADDR_W] = s.branch_addr;
    w[FSB_STEP_CODE_LSB +: 3] = s.code;
    w[FSB_STEP_PCRC_BIT] = s.process_crc;
    w[FSB_STEP_ALT_BIT] = s.alt_sel;
    return w;
  endfunction : step_word

  always_comb
  begin
    setup = i_psel && !i_penable;
    access = i_psel && i_penable && pready_reg;
    store_off = i_paddr - FSB_OFF_STORE;
    store_idx = store_off[FSB_ADDR_W+1:2];
    hit_ctrl = i_paddr == FSB_OFF_CTRL;
    hit_status = i_paddr == FSB_OFF_STATUS;
    hit_store = (i_paddr >= FSB_OFF_STORE) && (store_off[1:0] == 2'b00)
      && (int'(store_off[FSB_PADDR_W-1:2]) < STEPS);
    wr_ctrl = access && i_pwrite && hit_ctrl;
    wr_store = access && i_pwrite && hit_store;
    start_wr = wr_ctrl && i_pwdata[FSB_CTRL_START_BIT];
    wr_step.next_addr = i_pwdata[FSB_STEP_NEXT_LSB +: FSB_ADDR_W];
    wr_step.branch_addr = i_pwdata[FSB_STEP_BR_LSB +: FSB_ADDR_W];
    wr_step.code = i_pwdata[FSB_STEP_CODE_LSB +: 3];
    wr_step.process_crc = i_pwdata[FSB_STEP_PCRC_BIT];
    wr_step.alt_sel = i_pwdata[FSB_STEP_ALT_BIT];
    pready_next = setup;
    pslverr_next = setup && !(hit_ctrl || hit_status || hit_store);
    prdata_next = 32'h0;
    if (setup && !i_pwrite)
    begin
      if (hit_ctrl)
        prdata_next[FSB_CTRL_ADDR_LSB +: FSB_ADDR_W] = start_addr_reg;
      else if (hit_status)
      begin
        prdata_next[FSB_STAT_STATE_LSB +: 2] = state_reg;
        prdata_next[FSB_STAT_PC_LSB +: FSB_ADDR_W] = pc_reg;
        prdata_next[FSB_STAT_OUT_LSB +: 2] = last_out_reg;
      end
      else if (hit_store)
        prdata_next = step_word(store_reg[store_idx]);
    end
    start_addr_next = wr_ctrl ? i_pwdata[FSB_CTRL_ADDR_LSB +: FSB_ADDR_W] : start_addr_reg;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      start_addr_reg <= FSB_RST_START;
    end
    else
    begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      start_addr_reg <= start_addr_next;
    end
  end

  // control store, one flop word per step
  for (genvar i = 0; i < STEPS; i++)
  begin : g_store
    always_comb
    begin
      store_next[i] = (wr_store && int'(store_idx) == i) ? wr_step : store_reg[i];
    end

    always_ff @(posedge i_clock)
    begin
      if (i_srst)
        store_reg[i] <= '0;
      else
        store_reg[i] <= store_next[i];
    end
  end

  // a step address past the store reads as code 000 to step 0, never x
  assign cur_step = (int'(pc_reg) < STEPS) ? store_reg[pc_reg] : '0;
  assign cond = '{crc_error: i_crc_error, compare_ne: i_compare_ne,
    id_field_flag: pin_sync_reg[2], sector_mark_detect: pin_sync_reg[1],
    read_gate: pin_sync_reg[0]};

  fsb_branch_decode u_decode (
    .i_step(cur_step),
    .i_cond(cond),
    .o_use_alt(use_alt),
    .o_outcome(outcome)
  );

  // sequencer: one step per clock while running; a start write wins over execution
  always_comb
  begin
    state_next = state_reg;
    pc_next = pc_reg;
    last_out_next = last_out_reg;
    if (start_wr)
    begin
      state_next = FSB_ST_RUN;
      pc_next = i_pwdata[FSB_CTRL_ADDR_LSB +: FSB_ADDR_W];
    end
    else
    begin
      unique case (state_reg)
        FSB_ST_IDLE: state_next = FSB_ST_IDLE;
        FSB_ST_RUN:
        begin
          last_out_next = outcome;
          unique case (outcome)
            FSB_GO_NEXT: pc_next = cur_step.next_addr;
            FSB_GO_BRANCH: pc_next = cur_step.branch_addr;
            FSB_GO_STOP: state_next = FSB_ST_STOP;
            default: state_next = FSB_ST_STOP;
          endcase
        end
        FSB_ST_STOP: state_next = FSB_ST_STOP;
        default: state_next = FSB_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      state_reg <= FSB_ST_IDLE;
      pc_reg <= FSB_RST_PC;
      last_out_reg <= FSB_GO_NEXT;
    end
    else
    begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      last_out_reg <= last_out_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_step_addr = pc_reg;
  // state codes are one-hot apart from idle, so each bit is a status flop
  assign o_running = state_reg[0];
  assign o_stopped = state_reg[1];

  logic ex_p, ex_a, bad;
  assign ex_p = (state_reg == FSB_ST_RUN) && !start_wr && !use_alt;
  assign ex_a = (state_reg == FSB_ST_RUN) && !start_wr && use_alt;
  assign bad = i_crc_error || i_compare_ne;

  property p_prim_101;
    @(posedge i_clock) disable iff (i_srst)
    ex_p && cur_step.code == FSB_BC_101 |=> pc_reg == ($past(i_crc_error)
      ? $past(cur_step.branch_addr) : $past(cur_step.next_addr));
  endproperty
  a_prim_101: assert property (p_prim_101) else $error("code 101 target wrong");

  property p_prim_110;
    @(posedge i_clock) disable iff (i_srst)
    ex_p && cur_step.code == FSB_BC_110 |=> pc_reg == ($past(i_compare_ne)
      ? $past(cur_step.branch_addr) : $past(cur_step.next_addr));
  endproperty
  a_prim_110: assert property (p_prim_110) else $error("code 110 target wrong");

  property p_prim_111;
    @(posedge i_clock) disable iff (i_srst)
    ex_p && cur_step.code == FSB_BC_111 |=> pc_reg == ($past(bad)
      ? $past(cur_step.branch_addr) : $past(cur_step.next_addr));
  endproperty
  a_prim_111: assert property (p_prim_111) else $error("code 111 target wrong");

  property p_select;
    @(posedge i_clock) disable iff (i_srst)
    (state_reg == FSB_ST_RUN) && !start_wr && cur_step.code == FSB_BC_001
      && (cur_step.alt_sel || (cur_step.process_crc && pin_sync_reg[0]))
      |=> state_reg == FSB_ST_RUN;
  endproperty
  a_select: assert property (p_select) else $error("alternate set used wrongly");

  property p_alt_000;
    @(posedge i_clock) disable iff (i_srst)
    ex_a && cur_step.code == FSB_BC_000
      |=> state_reg == FSB_ST_RUN && pc_reg == $past(cur_step.next_addr);
  endproperty
  a_alt_000: assert property (p_alt_000) else $error("alt 000 did not continue");

  property p_alt_001;
    @(posedge i_clock) disable iff (i_srst)
    ex_a && cur_step.code == FSB_BC_001 && pin_sync_reg[2]
      |=> state_reg == FSB_ST_STOP && $stable(pc_reg);
  endproperty
  a_alt_001: assert property (p_alt_001) else $error("alt 001 did not stop");

  property p_alt_010;
    @(posedge i_clock) disable iff (i_srst)
    ex_a && cur_step.code == FSB_BC_010 |=> state_reg == ($past(pin_sync_reg[1])
      ? FSB_ST_STOP : FSB_ST_RUN);
  endproperty
  a_alt_010: assert property (p_alt_010) else $error("alt 010 stop wrong");

  property p_alt_011;
    @(posedge i_clock) disable iff (i_srst)
    ex_a && cur_step.code == FSB_BC_011 |=> state_reg == ($past(i_compare_ne)
      ? FSB_ST_STOP : FSB_ST_RUN);
  endproperty
  a_alt_011: assert property (p_alt_011) else $error("alt 011 stop wrong");

  property p_alt_100;
    @(posedge i_clock) disable iff (i_srst)
    ex_a && cur_step.code == FSB_BC_100 |=> pc_reg == $past(cur_step.branch_addr);
  endproperty
  a_alt_100: assert property (p_alt_100) else $error("alt 100 did not branch");

  property p_alt_101;
    @(posedge i_clock) disable iff (i_srst)
    ex_a && cur_step.code == FSB_BC_101 |=> pc_reg == ($past(pin_sync_reg[2])
      ? $past(cur_step.branch_addr) : $past(cur_step.next_addr));
  endproperty
  a_alt_101: assert property (p_alt_101) else $error("alt 101 target wrong");

  property p_prim_100;
    @(posedge i_clock) disable iff (i_srst)
    ex_p && cur_step.code == FSB_BC_100 |=> pc_reg == ($past(bad)
      ? $past(cur_step.next_addr) : $past(cur_step.branch_addr));
  endproperty
  a_prim_100: assert property (p_prim_100) else $error("code 100 target wrong");

  property p_prim_011;
    @(posedge i_clock) disable iff (i_srst)
    ex_p && cur_step.code == FSB_BC_011 |=> state_reg == ($past(bad)
      ? FSB_ST_STOP : FSB_ST_RUN);
  endproperty
  a_prim_011: assert property (p_prim_011) else $error("code 011 stop wrong");

  property p_prim_010;
    @(posedge i_clock) disable iff (i_srst)
    ex_p && cur_step.code == FSB_BC_010 |=> state_reg == ($past(i_compare_ne)
      ? FSB_ST_STOP : FSB_ST_RUN);
  endproperty
  a_prim_010: assert property (p_prim_010) else $error("code 010 stop wrong");

  property p_hold;
    @(posedge i_clock) disable iff (i_srst)
    state_reg == FSB_ST_STOP && !start_wr |=> state_reg == FSB_ST_STOP && $stable(pc_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped sequencer moved");
endmodule : fsb_sequencer
`default_nettype wire

// file: verification/fsb_read_channel_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsb_read_channel_model
  import fsb_pkg::*;
(
  input wire logic i_clock,
  input wire fsb_cond_t i_cmd,
  output var logic o_crc_error,
  output var logic o_compare_ne,
  output var logic o_id_field_flag,
  output var logic o_sector_mark_detect,
  output var logic o_read_gate
);
  // pins move only just after a rising edge, as the read channel's would
  initial
  begin
    o_crc_error = 1'b0;
    o_compare_ne = 1'b0;
    o_id_field_flag = 1'b0;
    o_sector_mark_detect = 1'b0;
    o_read_gate = 1'b0;
  end
  always @(posedge i_clock)
  begin
    o_crc_error <= i_cmd.crc_error;
    o_compare_ne <= i_cmd.compare_ne;
    o_id_field_flag <= i_cmd.id_field_flag;
    o_sector_mark_detect <= i_cmd.sector_mark_detect;
    o_read_gate <= i_cmd.read_gate;
  end
endmodule : fsb_read_channel_model
`default_nettype wire

// file: verification/format_sequencer_branch_decode_tb.sv
`timescale 1ns/100ps
`default_nettype none
module format_sequencer_branch_decode_tb
  import fsb_pkg::*;
;
  localparam int STEPS = 31;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [FSB_PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fsb_cond_t cond = '0;
  logic crc_error, compare_ne, id_field_flag, sector_mark_detect, read_gate;
  logic [FSB_ADDR_W-1:0] step_addr;
  logic running;
  logic stopped;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cycles = 0;
  logic [31:0] rd;
  logic er;

  always #2.5 i_clock = ~i_clock;

  fsb_read_channel_model u_chan (.i_clock(i_clock), .i_cmd(cond), .o_crc_error(crc_error),
    .o_compare_ne(compare_ne), .o_id_field_flag(id_field_flag),
    .o_sector_mark_detect(sector_mark_detect), .o_read_gate(read_gate));

  fsb_sequencer #(.STEPS(STEPS)) u_dut (.i_clock(i_clock), .i_srst(i_srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_crc_error(crc_error),
    .i_compare_ne(compare_ne), .i_id_field_flag(id_field_flag),
    .i_sector_mark_detect(sector_mark_detect), .i_read_gate(read_gate),
    .o_step_addr(step_addr), .o_running(running), .o_stopped(stopped));

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // a hung slave is left to the cycle ceiling rather than a local limit
  always @(posedge i_clock)
  begin
    n_cycles <= n_cycles + 1;
    if (n_cycles == 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do
      @(posedge i_clock);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_case(input logic alt, input logic pcrc, input logic [2:0] code,
    input logic [4:0] c, input fsb_outcome_t oc);
    logic [31:0] wd;
    logic [4:0] st;
    logic [1:0] sv;
    wd = '0;
    wd[FSB_STEP_ALT_BIT] = alt;
    wd[FSB_STEP_PCRC_BIT] = pcrc;
    wd[FSB_STEP_CODE_LSB +: 3] = code;
    wd[FSB_STEP_BR_LSB +: FSB_ADDR_W] = 5'h02;
    wd[FSB_STEP_NEXT_LSB +: FSB_ADDR_W] = 5'h01;
    cond <= fsb_cond_t'(c);
    // the write and read-back outlast the pin synchronisers
    apb(1'b1, FSB_OFF_STORE, wd, rd, er);
    apb(1'b0, FSB_OFF_STORE, '0, rd, er);
    check(rd, wd);
    apb(1'b1, FSB_OFF_CTRL, 32'h0000_0001, rd, er);
    @(posedge i_clock);
    #1;
    st = (oc == FSB_GO_STOP) ? 5'h00 : ((oc == FSB_GO_BRANCH) ? 5'h02 : 5'h01);
    // packed as {running, stopped}
    sv = (oc == FSB_GO_STOP) ? 2'b01 : 2'b10;
    check({25'h0, running, stopped, step_addr}, {25'h0, sv, st});
    // steps 1 and 2 loop on themselves, so a running case reports a branch
    apb(1'b0, FSB_OFF_STATUS, '0, rd, er);
    if (oc == FSB_GO_STOP)
      check(rd, 32'h0002_0002);
    else
      check(rd, {14'h0, 2'b01, 3'h0, st, 6'h0, 2'b01});
  endtask : run_case

  initial
  begin
    repeat (10) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    #1;
    check({25'h0, running, stopped, step_addr}, 32'h0);
    apb(1'b0, FSB_OFF_STATUS, '0, rd, er);
    check(rd, 32'h0);
    apb(1'b0, 8'h08, '0, rd, er);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    apb(1'b0, FSB_OFF_STORE + 8'(4 * STEPS), '0, rd, er);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    // steps 1 and 2 are alternate code 100 branching to themselves
    apb(1'b1, FSB_OFF_STORE + 8'h04, 32'h0004_0101, rd, er);
    apb(1'b1, FSB_OFF_STORE + 8'h08, 32'h0004_0202, rd, er);
    run_case(1'b1, 1'b0, FSB_BC_101, 5'b10000, FSB_GO_BRANCH);
    run_case(1'b1, 1'b0, FSB_BC_101, 5'b01111, FSB_GO_NEXT);
    run_case(1'b1, 1'b0, FSB_BC_110, 5'b01000, FSB_GO_BRANCH);
    run_case(1'b1, 1'b0, FSB_BC_110, 5'b10111, FSB_GO_NEXT);
    run_case(1'b1, 1'b0, FSB_BC_111, 5'b10000, FSB_GO_BRANCH);
    run_case(1'b1, 1'b0, FSB_BC_111, 5'b01000, FSB_GO_BRANCH);
    run_case(1'b1, 1'b0, FSB_BC_111, 5'b00111, FSB_GO_NEXT);
    run_case(1'b1, 1'b0, FSB_BC_100, 5'b00000, FSB_GO_BRANCH);
    run_case(1'b1, 1'b0, FSB_BC_100, 5'b10000, FSB_GO_NEXT);
    run_case(1'b1, 1'b0, FSB_BC_100, 5'b01000, FSB_GO_NEXT);
    run_case(1'b1, 1'b0, FSB_BC_011, 5'b10000, FSB_GO_STOP);
    run_case(1'b1, 1'b0, FSB_BC_011, 5'b01000, FSB_GO_STOP);
    run_case(1'b1, 1'b0, FSB_BC_011, 5'b00111, FSB_GO_NEXT);
    run_case(1'b1, 1'b0, FSB_BC_010, 5'b01000, FSB_GO_STOP);
    run_case(1'b1, 1'b0, FSB_BC_010, 5'b10111, FSB_GO_NEXT);
    run_case(1'b0, 1'b0, FSB_BC_000, 5'b11111, FSB_GO_NEXT);
    run_case(1'b0, 1'b0, FSB_BC_001, 5'b00100, FSB_GO_STOP);
    run_case(1'b0, 1'b0, FSB_BC_001, 5'b11011, FSB_GO_NEXT);
    run_case(1'b0, 1'b0, FSB_BC_010, 5'b00010, FSB_GO_STOP);
    run_case(1'b0, 1'b0, FSB_BC_010, 5'b11101, FSB_GO_NEXT);
    run_case(1'b0, 1'b0, FSB_BC_011, 5'b01000, FSB_GO_STOP);
    run_case(1'b0, 1'b0, FSB_BC_011, 5'b10111, FSB_GO_NEXT);
    run_case(1'b0, 1'b0, FSB_BC_100, 5'b00000, FSB_GO_BRANCH);
    run_case(1'b0, 1'b0, FSB_BC_101, 5'b00100, FSB_GO_BRANCH);
    run_case(1'b0, 1'b0, FSB_BC_101, 5'b11011, FSB_GO_NEXT);
    run_case(1'b0, 1'b1, FSB_BC_010, 5'b01001, FSB_GO_STOP);
    run_case(1'b0, 1'b1, FSB_BC_010, 5'b01000, FSB_GO_NEXT);
    run_case(1'b0, 1'b0, FSB_BC_010, 5'b01001, FSB_GO_NEXT);
    run_case(1'b1, 1'b1, FSB_BC_010, 5'b01000, FSB_GO_STOP);
    run_case(1'b1, 1'b0, FSB_BC_001, 5'b00100, FSB_GO_NEXT);
    complete_run();
  end
endmodule : format_sequencer_branch_decode_tb
`default_nettype wire
